// [hw/pcc_pkg.sv]
// Shared constants for the counter-array capture/compare block.
// Assumes an 8-bit special-function-register port driven by a CPU on sys_clk.
package pcc_pkg;

   localparam int unsigned PCC_NUM_MOD = 3;

   // Register indices on the 8-bit register port.
   localparam logic [7:0] PCC_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] PCC_ADDR_SETUP  = 8'h01;
   localparam logic [7:0] PCC_ADDR_CNTL   = 8'h02;
   localparam logic [7:0] PCC_ADDR_CNTH   = 8'h03;
   localparam logic [7:0] PCC_ADDR_MODE0  = 8'h04;
   localparam logic [7:0] PCC_ADDR_CPL0   = 8'h08;
   localparam logic [7:0] PCC_ADDR_CPH0   = 8'h0c;
   localparam logic [7:0] PCC_ADDR_PIN    = 8'h0f;

   // Fields of module_mode_config.
   localparam int unsigned PCC_MB_WIDE  = 7;
   localparam int unsigned PCC_MB_ECOM  = 6;
   localparam int unsigned PCC_MB_RISE  = 5;
   localparam int unsigned PCC_MB_FALL  = 4;
   localparam int unsigned PCC_MB_MAT   = 3;
   localparam int unsigned PCC_MB_FLIP  = 2;
   localparam int unsigned PCC_MB_PULSE = 1;
   localparam int unsigned PCC_MB_IRQ   = 0;

   // Fields of counter_control_reg.
   localparam int unsigned PCC_CB_CF  = 7;
   localparam int unsigned PCC_CB_RUN = 6;

   // Fields of counter_setup_reg.
   localparam int unsigned PCC_SB_TB_LO = 1;
   localparam int unsigned PCC_SB_ECF   = 0;

   // Timebase codes.
   localparam logic [2:0] PCC_TB_DIV12 = 3'h0;
   localparam logic [2:0] PCC_TB_DIV4  = 3'h1;
   localparam logic [2:0] PCC_TB_T0OVF = 3'h2;
   localparam logic [2:0] PCC_TB_ECI   = 3'h3;
   localparam logic [2:0] PCC_TB_SYS   = 3'h4;
   localparam logic [2:0] PCC_TB_OSC8  = 3'h5;

   localparam logic [3:0] PCC_DIV12_LAST = 4'hb;
   localparam logic [1:0] PCC_DIV4_LAST  = 2'h3;
   localparam logic [2:0] PCC_OSC8_LAST  = 3'h7;

   localparam logic [7:0]  PCC_BYTE_MAX = 8'hff;
   localparam logic [15:0] PCC_WORD_MAX = 16'hffff;

   typedef enum logic [2:0] {
      PCC_M_IDLE,
      PCC_M_CAPT,
      PCC_M_SWT,
      PCC_M_HSO,
      PCC_M_FREQ,
      PCC_M_PWM8,
      PCC_M_PWM16,
      PCC_M_PWMOFF
   } pcc_mode_t;

endpackage

// [hw/pcc_sync2.sv]
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is held long enough to be seen on two sys_clk edges.
`timescale 1ns/1ps
`default_nettype none
module pcc_sync2 (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // pcc_sync2
`default_nettype wire

// [hw/pcc_capture_compare.sv]
// Shared 16-bit counter with three capture/compare modules and their I/O lines.
// Assumes a CPU on sys_clk using the 8-bit register port and supplying the
// global and block interrupt enables and the timer 0 overflow pulse.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each module picks its own mode independently
// - Rise/fall enables select capture edge
// - Valid edge copies counter into compare word
// - Capture sets event flag, may interrupt
// - Flags cleared only by software
// - Pin level readable to tell edge direction
// - Software timer flags on 16-bit match
// - Software timer needs comparator and event enables
// - Low write clears, high write sets comparator
// - High-speed output toggles line per match
// - Frequency mode toggles, adds high to low
// - Square wave is counter rate over 2*high
// - Frequency mode needs comparator, flip, pulse enables
// - PWM8 sets on low match, clears on overflow
// - PWM8 reloads low byte from high byte
// - PWM8 high fraction is (256-high)/256
// - Pulse modes; wide select picks 16-bit
// - PWM16 sets on match, clears on overflow
// - PWM16 fraction; comparator off gives zero
// - Interrupt needs module, block, global enables
// - Shared counter plus three independent modules
// - Three-bit timebase selects counter clock
module pcc_capture_compare
   import pcc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       global_irq_enable,
   input  wire logic       block_irq_enable,
   input  wire logic       timer0_overflow,
   input  wire logic       external_count_input,
   input  wire logic       ext_osc_clk,
   input  wire logic [2:0] module_io_in,
   output logic      [2:0] module_io_out,
   output logic      [2:0] module_io_oe,
   output logic            irq
);

   typedef struct packed {
      logic [15:0]      cnt;
      logic [7:0]       snap;
      logic             cf;
      logic             run;
      logic [2:0]       tb;
      logic             ecf;
      logic [3:0]       div12;
      logic [1:0]       div4;
      logic [2:0]       osc_div;
      logic             eci_prev;
      logic             osc_prev;
      logic [2:0]       pin_prev;
      logic [2:0][7:0]  mode;
      logic [2:0][7:0]  cpl;
      logic [2:0][7:0]  cph;
      logic [2:0]       ccf;
      logic [2:0]       out;
      logic [2:0]       oe;
      logic             irq;
      logic [7:0]       rdata;
   } pcc_state_t;

   pcc_state_t s_q;
   pcc_state_t s_d;

   logic       eci_s;
   logic       osc_s;
   logic [2:0] pin_s;

   // The other party keeps each level for two clocks, so a level is never
   // missed by the two-stage sampling below.
   pcc_sync2 u_sync_eci (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       (external_count_input),
      .q       (eci_s)
   );

   pcc_sync2 u_sync_osc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       (ext_osc_clk),
      .q       (osc_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < PCC_NUM_MOD; gi++) begin : g_pin_sync
         pcc_sync2 u_sync_pin (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .d       (module_io_in[gi]),
            .q       (pin_s[gi])
         );
      end
   endgenerate

   // One decoder serves every module, so each module follows its own
   // configuration byte only.
   function automatic pcc_mode_t pcc_decode(input logic [7:0] m);
      pcc_mode_t r;
      r = PCC_M_IDLE;
      if ((m[PCC_MB_RISE] || m[PCC_MB_FALL]) && !m[PCC_MB_MAT] && !m[PCC_MB_FLIP]
          && !m[PCC_MB_PULSE]) begin
         r = PCC_M_CAPT;
      end else if (m[PCC_MB_RISE] || m[PCC_MB_FALL]) begin
         r = PCC_M_IDLE;
      end else if (m[PCC_MB_PULSE] && !m[PCC_MB_ECOM]) begin
         r = PCC_M_PWMOFF;
      end else if (!m[PCC_MB_ECOM]) begin
         r = PCC_M_IDLE;
      end else if (m[PCC_MB_PULSE] && m[PCC_MB_FLIP]) begin
         r = PCC_M_FREQ;
      end else if (m[PCC_MB_PULSE]) begin
         r = m[PCC_MB_WIDE] ? PCC_M_PWM16 : PCC_M_PWM8;
      end else if (m[PCC_MB_MAT] && m[PCC_MB_FLIP]) begin
         r = PCC_M_HSO;
      end else if (m[PCC_MB_MAT]) begin
         r = PCC_M_SWT;
      end
      return r;
   endfunction

   always_comb begin
      logic        tick;
      logic [15:0] cnt_nxt;
      logic        ovf16;
      logic        ovf8;
      logic        osc_tick;
      logic [7:0]  lo_ref;
      logic        edge_hit;
      logic [7:0]  rd;
      pcc_mode_t   md;
      int          i;

      s_d      = s_q;
      tick     = 1'b0;
      cnt_nxt  = 16'h0000;
      ovf16    = 1'b0;
      ovf8     = 1'b0;
      i        = 0;
      osc_tick = 1'b0;
      lo_ref   = 8'h00;
      edge_hit = 1'b0;
      rd       = 8'h00;
      md       = PCC_M_IDLE;

      // Prescalers run freely so that a timebase change takes effect at once.
      s_d.div12 = (s_q.div12 == PCC_DIV12_LAST) ? 4'h0 : s_q.div12 + 4'h1;
      s_d.div4  = s_q.div4 + 2'h1;
      s_d.eci_prev = eci_s;
      s_d.osc_prev = osc_s;
      if (osc_s && !s_q.osc_prev) begin
         s_d.osc_div = s_q.osc_div + 3'h1;
         osc_tick    = (s_q.osc_div == PCC_OSC8_LAST);
      end

      case (s_q.tb)
         PCC_TB_DIV12: tick = (s_q.div12 == PCC_DIV12_LAST);
         PCC_TB_DIV4:  tick = (s_q.div4 == PCC_DIV4_LAST);
         PCC_TB_T0OVF: tick = timer0_overflow;
         PCC_TB_ECI:   tick = s_q.eci_prev && !eci_s;
         PCC_TB_SYS:   tick = 1'b1;
         PCC_TB_OSC8:  tick = osc_tick;
         default:      tick = 1'b0;
      endcase
      tick    = tick && s_q.run;
      cnt_nxt = s_q.cnt + 16'h0001;
      ovf16   = tick && (s_q.cnt == PCC_WORD_MAX);
      ovf8    = tick && (s_q.cnt[7:0] == PCC_BYTE_MAX);

      // Software side. A counter write beats a tick in the same cycle.
      if (sfr_wr) begin
         if (sfr_addr == PCC_ADDR_CTRL) begin
            s_d.cf  = sfr_wdata[PCC_CB_CF];
            s_d.run = sfr_wdata[PCC_CB_RUN];
            s_d.ccf = sfr_wdata[PCC_NUM_MOD-1:0];
         end
         if (sfr_addr == PCC_ADDR_SETUP) begin
            s_d.tb  = sfr_wdata[PCC_SB_TB_LO +: 3];
            s_d.ecf = sfr_wdata[PCC_SB_ECF];
         end
      end
      if (tick) begin
         s_d.cnt = cnt_nxt;
      end
      if (sfr_wr && sfr_addr == PCC_ADDR_CNTL) begin
         s_d.cnt[7:0] = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == PCC_ADDR_CNTH) begin
         s_d.cnt[15:8] = sfr_wdata;
      end
      if (ovf16) begin
         s_d.cf = 1'b1;
      end

      s_d.pin_prev = pin_s;
      for (i = 0; i < PCC_NUM_MOD; i++) begin
         if (sfr_wr && sfr_addr == PCC_ADDR_MODE0 + 8'(i)) begin
            s_d.mode[i] = sfr_wdata;
         end
         if (sfr_wr && sfr_addr == PCC_ADDR_CPL0 + 8'(i)) begin
            s_d.cpl[i]              = sfr_wdata;
            s_d.mode[i][PCC_MB_ECOM] = 1'b0;
         end
         if (sfr_wr && sfr_addr == PCC_ADDR_CPH0 + 8'(i)) begin
            s_d.cph[i]              = sfr_wdata;
            s_d.mode[i][PCC_MB_ECOM] = 1'b1;
         end

         md = pcc_decode(s_q.mode[i]);
         case (md)
            PCC_M_CAPT: begin
               edge_hit = (s_q.mode[i][PCC_MB_RISE] && pin_s[i] && !s_q.pin_prev[i])
                       || (s_q.mode[i][PCC_MB_FALL] && !pin_s[i] && s_q.pin_prev[i]);
               if (edge_hit) begin
                  // A capture outranks a software write to the same byte.
                  s_d.cpl[i] = s_q.cnt[7:0];
                  s_d.cph[i] = s_q.cnt[15:8];
                  s_d.ccf[i] = 1'b1;
               end
            end
            PCC_M_SWT: begin
               if (tick && cnt_nxt == {s_q.cph[i], s_q.cpl[i]}) begin
                  s_d.ccf[i] = 1'b1;
               end
            end
            PCC_M_HSO: begin
               if (tick && cnt_nxt == {s_q.cph[i], s_q.cpl[i]}) begin
                  s_d.out[i] = !s_q.out[i];
                  s_d.ccf[i] = 1'b1;
               end
            end
            PCC_M_FREQ: begin
               // Half a period is high-byte ticks, giving rate/(2*high).
               if (tick && cnt_nxt[7:0] == s_q.cpl[i]) begin
                  s_d.out[i] = !s_q.out[i];
                  s_d.cpl[i] = s_q.cpl[i] + s_q.cph[i];
                  if (s_q.mode[i][PCC_MB_MAT]) begin
                     s_d.ccf[i] = 1'b1;
                  end
               end
            end
            PCC_M_PWM8: begin
               // The match is taken against the reloaded byte at rollover, so a
               // high byte of zero keeps the line high all the time.
               lo_ref = ovf8 ? s_q.cph[i] : s_q.cpl[i];
               if (ovf8) begin
                  s_d.cpl[i] = s_q.cph[i];
                  s_d.out[i] = 1'b0;
               end
               if (tick && cnt_nxt[7:0] == lo_ref) begin
                  s_d.out[i] = 1'b1;
                  if (s_q.mode[i][PCC_MB_MAT]) begin
                     s_d.ccf[i] = 1'b1;
                  end
               end
            end
            PCC_M_PWM16: begin
               if (ovf16) begin
                  s_d.out[i] = 1'b0;
               end
               if (tick && cnt_nxt == {s_q.cph[i], s_q.cpl[i]}) begin
                  s_d.out[i] = 1'b1;
                  if (s_q.mode[i][PCC_MB_MAT]) begin
                     s_d.ccf[i] = 1'b1;
                  end
               end
            end
            PCC_M_PWMOFF: begin
               s_d.out[i] = 1'b0;
            end
            default: begin
               s_d.out[i] = s_q.out[i];
            end
         endcase
         s_d.oe[i] = (md == PCC_M_HSO) || (md == PCC_M_FREQ) || (md == PCC_M_PWM8)
                  || (md == PCC_M_PWM16) || (md == PCC_M_PWMOFF);
      end

      // Interrupt request from flag and enables.
      s_d.irq = global_irq_enable && block_irq_enable
             && ((s_q.cf && s_q.ecf)
                 || (s_q.ccf[0] && s_q.mode[0][PCC_MB_IRQ])
                 || (s_q.ccf[1] && s_q.mode[1][PCC_MB_IRQ])
                 || (s_q.ccf[2] && s_q.mode[2][PCC_MB_IRQ]));

      // Reading the counter low byte freezes the high byte for a torn-free read.
      if (sfr_rd) begin
         case (sfr_addr)
            PCC_ADDR_CTRL:  rd = {s_q.cf, s_q.run, 3'h0, s_q.ccf};
            PCC_ADDR_SETUP: rd = {4'h0, s_q.tb, s_q.ecf};
            PCC_ADDR_CNTL:  rd = s_q.cnt[7:0];
            PCC_ADDR_CNTH:  rd = s_q.snap;
            PCC_ADDR_PIN:   rd = {5'h00, pin_s};
            default:        rd = 8'h00;
         endcase
         for (i = 0; i < PCC_NUM_MOD; i++) begin
            if (sfr_addr == PCC_ADDR_MODE0 + 8'(i)) rd = s_q.mode[i];
            if (sfr_addr == PCC_ADDR_CPL0 + 8'(i))  rd = s_q.cpl[i];
            if (sfr_addr == PCC_ADDR_CPH0 + 8'(i))  rd = s_q.cph[i];
         end
         if (sfr_addr == PCC_ADDR_CNTL) begin
            s_d.snap = s_q.cnt[15:8];
         end
         s_d.rdata = rd;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata     = s_q.rdata;
   assign module_io_out = s_q.out;
   assign module_io_oe  = s_q.oe;
   assign irq           = s_q.irq;

endmodule // pcc_capture_compare
`default_nettype wire

// [tb/pcc_capture_compare_assertions.sv]
// Checker for the capture/compare block, bound to its top module.
// Sees only top ports; mirrors the module 0 mode byte from register writes.
`timescale 1ns/1ps
`default_nettype none
module pcc_capture_compare_checker
   import pcc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       global_irq_enable,
   input wire logic       block_irq_enable,
   input wire logic [2:0] module_io_in,
   input wire logic [2:0] module_io_out,
   input wire logic [2:0] module_io_oe,
   input wire logic       irq
);
   logic [7:0] m0_q;
   logic       pwm_off;
   logic       capt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // The low compare byte write drops the comparator, the high one raises it.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         m0_q <= 8'h00;
      else if (sfr_wr && sfr_addr == PCC_ADDR_MODE0)
         m0_q <= sfr_wdata;
      else if (sfr_wr && sfr_addr == PCC_ADDR_CPL0)
         m0_q[PCC_MB_ECOM] <= 1'b0;
      else if (sfr_wr && sfr_addr == PCC_ADDR_CPH0)
         m0_q[PCC_MB_ECOM] <= 1'b1;
   end
   assign pwm_off = m0_q[1] && !m0_q[6] && m0_q[5:4] == 2'b00 && !m0_q[2];
   assign capt = m0_q[5:4] != 2'b00 && m0_q[3:1] == 3'b000;

   irq_gate_a: assert property (!(global_irq_enable && block_irq_enable) |=> !irq)
      else $error("irq raised while interrupts disabled");
   flag_sticky_a: assert property (irq && !sfr_wr && !$past(sfr_wr)
      && global_irq_enable && block_irq_enable |=> irq)
      else $error("irq dropped without software clear");
   pin_read_a: assert property (sfr_rd && sfr_addr == PCC_ADDR_PIN
      |=> sfr_rdata == {5'h00, $past(module_io_in, 3)})
      else $error("pin level read wrong");
   rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   unmapped_zero_a: assert property (sfr_rd && sfr_addr == 8'h07 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   oe_cause_a: assert property ($changed(module_io_oe) |-> $past(sfr_wr) || $past(sfr_wr, 2))
      else $error("drive enable changed with no mode write");
   pwm_zero_a: assert property (pwm_off && $past(pwm_off) && $past(pwm_off, 2)
      |-> module_io_out[0] == 1'b0 && module_io_oe[0] == 1'b1)
      else $error("pulse output not held low with comparator off");
   capt_input_a: assert property (capt && $past(capt) && $past(capt, 2)
      |-> module_io_oe[0] == 1'b0)
      else $error("capture line driven");
endmodule // pcc_capture_compare_checker
bind pcc_capture_compare pcc_capture_compare_checker u_pcc_capture_compare_checker (
   .sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .global_irq_enable,
   .block_irq_enable, .module_io_in, .module_io_out, .module_io_oe, .irq);
`default_nettype wire

// [tb/pcc_pin_model.sv]
// Sources and loads on the three module lines.
// Assumes the bench asks for levels on want and the block drives through oe.
`timescale 1ns/1ps
`default_nettype none
module pcc_pin_model (
   input  wire logic       sys_clk,
   input  wire logic [2:0] want,
   input  wire logic [2:0] oe,
   input  wire logic [2:0] drv,
   output logic      [2:0] line
);
   logic [2:0] lvl = 3'h0;
   int         age [3] = '{0, 0, 0};
   // A new level waits until the old one has stood three clocks.
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (want[i] !== lvl[i] && age[i] >= 2) begin
            lvl[i] <= want[i];
            age[i] <= 0;
         end else begin
            age[i] <= age[i] + 1;
         end
      end
   end
   assign line = (oe & drv) | (~oe & lvl);
endmodule // pcc_pin_model
`default_nettype wire

// [tb/pcc_capture_compare_bench.sv]
// Self-checking bench for the capture/compare block.
// Assumes the pin model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module pcc_capture_compare_bench
   import pcc_pkg::*;
;
   logic       sys_clk, rst_n, sfr_wr, sfr_rd, ge, be, zero, p, irq;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [2:0] want, pin, io_out, io_oe;
   int         fail_count, check_count, n, ones, last, rv, lf;

   function automatic int nxt(input int s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   pcc_capture_compare u_pcc_capture_compare (
      .sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .global_irq_enable(ge), .block_irq_enable(be), .timer0_overflow(zero),
      .external_count_input(zero), .ext_osc_clk(zero), .module_io_in(pin),
      .module_io_out(io_out), .module_io_oe(io_oe), .irq);
   pcc_pin_model u_pcc_pin_model (.sys_clk, .want, .oe(io_oe), .drv(io_out), .line(pin));

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge sys_clk);
      sfr_wr    <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string s);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge sys_clk);
      sfr_rd   <= 1'b0;
      #1 chk(s, {8'h00, e}, {8'h00, sfr_rdata});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      ge = 1'b1;
      be = 1'b1;
      zero = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      want = 3'h0;
      lf = 32'h7d34;
      fail_count = 0;
      check_count = 0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rc(PCC_ADDR_CTRL, 8'h00, "ctrl reset");
      rc(PCC_ADDR_SETUP, 8'h00, "setup reset");
      rc(PCC_ADDR_MODE0, 8'h00, "mode reset");
      rc(8'h07, 8'h00, "unmapped");
      wr(PCC_ADDR_SETUP, {4'h0, PCC_TB_SYS, 1'b0});
      // Counter stopped, so a capture must return exactly the loaded count.
      for (int k = 1; k < 4; k++) begin
         lf = nxt(lf);
         wr(PCC_ADDR_CNTL, lf[7:0]);
         wr(PCC_ADDR_CNTH, lf[15:8]);
         wr(PCC_ADDR_MODE0, {2'b00, k[0], k[1], 4'h1});
         wr(PCC_ADDR_CTRL, 8'h00);
         for (int e = 1; e >= 0; e--) begin
            want[0] <= e[0];
            repeat (6) @(posedge sys_clk);
            #1 chk("irq", {15'h0, k[1 - e]}, {15'h0, irq});
            rc(PCC_ADDR_CTRL, {7'h0, k[1 - e]}, "flag");
            rc(PCC_ADDR_PIN, {7'h0, e[0]}, "pin");
            if (k[1 - e]) begin
               rc(PCC_ADDR_CPL0, lf[7:0], "cap lo");
               rc(PCC_ADDR_CPH0, lf[15:8], "cap hi");
            end
            wr(PCC_ADDR_CTRL, 8'h00);
         end
      end
      ge <= 1'b0;
      want[0] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 chk("irq off", 16'h0, {15'h0, irq});
      ge <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk("irq on", 16'h1, {15'h0, irq});
      wr(PCC_ADDR_CTRL, 8'h00);
      wr(PCC_ADDR_CNTL, 8'h00);
      wr(PCC_ADDR_CNTH, 8'h00);
      wr(PCC_ADDR_MODE0, 8'h49);
      lf = nxt(lf);
      rv = 64 + int'(lf[6:0]);
      wr(PCC_ADDR_CPL0, rv[7:0]);
      rc(PCC_ADDR_MODE0, 8'h09, "ecom low");
      wr(PCC_ADDR_CPH0, 8'h00);
      rc(PCC_ADDR_MODE0, 8'h49, "ecom high");
      wr(PCC_ADDR_CTRL, 8'h40);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("match time", 16'h1, {15'h0, n >= rv && n <= rv + 3});
      if (n >= 400)
         test_done();
      rc(PCC_ADDR_CTRL, 8'h41, "match flag");
      wr(PCC_ADDR_CTRL, 8'h00);
      lf = nxt(lf);
      rv = 2 + int'(lf[13:8]);
      wr(PCC_ADDR_CPL0, lf[7:0]);
      wr(PCC_ADDR_CPH0, lf[7:0]);
      wr(PCC_ADDR_MODE0, 8'h42);
      wr(PCC_ADDR_CPL0 + 8'h02, 8'h00);
      wr(PCC_ADDR_CPH0 + 8'h02, rv[7:0]);
      wr(PCC_ADDR_MODE0 + 8'h02, 8'h46);
      wr(PCC_ADDR_CTRL, 8'h40);
      repeat (300) @(posedge sys_clk);
      ones = 0;
      last = -1;
      p = io_out[2];
      for (int t = 0; t < 512; t++) begin
         @(posedge sys_clk);
         #1 ones += int'(io_out[0]);
         if (io_out[2] !== p) begin
            if (last >= 0) chk("freq gap", rv[15:0], 16'(t - last));
            last = t;
            p = io_out[2];
         end
      end
      chk("pwm8 high", 16'(512 - 2 * int'(lf[7:0])), ones[15:0]);
      chk("drives", 16'h0005, {13'h0, io_oe});
      wr(PCC_ADDR_CPL0, 8'h10);
      repeat (2) @(posedge sys_clk);
      ones = 0;
      repeat (300) begin
         @(posedge sys_clk);
         #1 ones += int'(io_out[0]);
      end
      chk("pwm off", 16'h0000, ones[15:0]);
      test_done();
   end
endmodule // pcc_capture_compare_bench
`default_nettype wire
